// ==== verilog/chan2_cfg_bank.sv ====
/*
  Channel 2 configuration register bank: analog gain with polarity, digital
  volume, gain trim and phase trim, plus the channel 3 volume register.
  Assumes a synchronous byte-wide register port driven by the control
  interface, with one-cycle write and read strobes.
*/
`timescale 1ns/1ps
module chan2_cfg_bank #(
  parameter int PHASE_DEPTH = 256
) (
  input  wire logic                          i_clk,
  input  wire logic                          i_rst,
  input  wire logic [7:0]                    i_addr,
  input  wire logic [7:0]                    i_wdata,
  input  wire logic                          i_wr,
  input  wire logic                          i_rd,
  input  wire logic                          i_mod_tick,
  input  wire logic                          i_sample_bit,
  output logic      [7:0]                    o_rdata,
  output logic                               o_rvalid,
  output chan_cfg_pkg::chan_setting_s        o_setting,
  output logic                               o_delayed_bit
);

  localparam int PHASE_AW = $clog2(PHASE_DEPTH);

  logic [7:0]                  chan2_analog_gain;
  logic [7:0]                  chan2_digital_volume;
  logic [3:0]                  chan2_gain_trim_code;
  logic [7:0]                  chan2_phase_trim;
  logic [7:0]                  chan3_digital_volume;
  logic                        wr_gain;
  logic                        wr_volume;
  logic                        wr_trim;
  logic                        wr_phase;
  logic                        wr_chan3_volume;
  logic [PHASE_AW-1:0]         phase_tap;
  chan_cfg_pkg::chan_setting_s next_setting;

  // Volume steps of half a dB, counted from the unity code.
  function automatic logic signed [8:0] vol_half_db(
    input logic [7:0] code
  );
    vol_half_db = $signed({1'b0, code})
                  - $signed({1'b0, chan_cfg_pkg::VOL_CODE_UNITY});
  endfunction

  // The polarity bit only negates the magnitude. The floor of the negative
  // range is the host's duty, so no clamp is applied here.
  function automatic logic signed [8:0] gain_half_db(
    input logic [6:0] code,
    input logic       negative
  );
    logic signed [8:0] mag;
    mag = $signed({2'b00, code});
    gain_half_db = negative ? -mag : mag;
  endfunction

  function automatic logic signed [4:0] trim_tenth_db(
    input logic [3:0] code
  );
    trim_tenth_db = $signed({1'b0, code})
                    - $signed({1'b0, chan_cfg_pkg::TRIM_CODE_UNITY});
  endfunction

  function automatic logic wr_hit(
    input logic [7:0] a
  );
    wr_hit = i_wr && (i_addr == a);
  endfunction

  // Reserved trim bits are never stored, so they always read back as zero.
  function automatic logic [7:0] read_view(
    input logic [7:0] a
  );
    unique case (a)
      chan_cfg_pkg::ADDR_CHAN2_ANALOG_GAIN:
        read_view = chan2_analog_gain;
      chan_cfg_pkg::ADDR_CHAN2_DIGITAL_VOLUME:
        read_view = chan2_digital_volume;
      chan_cfg_pkg::ADDR_CHAN2_GAIN_TRIM:
        read_view = {chan2_gain_trim_code,
                     chan_cfg_pkg::TRIM_RSVD_MASK};
      chan_cfg_pkg::ADDR_CHAN2_PHASE_TRIM:
        read_view = chan2_phase_trim;
      chan_cfg_pkg::ADDR_CHAN3_DIGITAL_VOLUME:
        read_view = chan3_digital_volume;
      default:
        read_view = 8'h00;
    endcase
  endfunction

  // One select per register keeps each storage process to its own hit;
  // writes to unmapped addresses match none of them and are dropped.
  always_comb begin
    wr_gain         = wr_hit(chan_cfg_pkg::ADDR_CHAN2_ANALOG_GAIN);
    wr_volume       = wr_hit(chan_cfg_pkg::ADDR_CHAN2_DIGITAL_VOLUME);
    wr_trim         = wr_hit(chan_cfg_pkg::ADDR_CHAN2_GAIN_TRIM);
    wr_phase        = wr_hit(chan_cfg_pkg::ADDR_CHAN2_PHASE_TRIM);
    wr_chan3_volume = wr_hit(chan_cfg_pkg::ADDR_CHAN3_DIGITAL_VOLUME);
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      chan2_analog_gain <= chan_cfg_pkg::RST_ANALOG_GAIN;
    end else if (wr_gain) begin
      chan2_analog_gain <= i_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      chan2_digital_volume <= chan_cfg_pkg::RST_DIGITAL_VOLUME;
    end else if (wr_volume) begin
      chan2_digital_volume <= i_wdata;
    end
  end

  // Only the upper nibble is stored, so the reserved bits cannot hold data.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      chan2_gain_trim_code <= chan_cfg_pkg::RST_GAIN_TRIM[7:4];
    end else if (wr_trim) begin
      chan2_gain_trim_code <= i_wdata[chan_cfg_pkg::TRIM_CODE_MSB:
                                      chan_cfg_pkg::TRIM_CODE_LSB];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      chan2_phase_trim <= chan_cfg_pkg::RST_PHASE_TRIM;
    end else if (wr_phase) begin
      chan2_phase_trim <= i_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      chan3_digital_volume <= chan_cfg_pkg::RST_DIGITAL_VOLUME;
    end else if (wr_chan3_volume) begin
      chan3_digital_volume <= i_wdata;
    end
  end

  // Unmapped addresses read as zero. A read in the cycle of a write to the
  // same register returns the value held before that write, and the data
  // then stands until the next read.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= i_rd;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      o_rdata <= read_view(i_addr);
    end
  end

  // Reserved gain codes are flagged but passed through; the analog stage
  // behaviour for them is undefined, so no clamp is imposed here.
  always_comb begin
    logic [6:0] gcode;
    gcode = chan2_analog_gain[chan_cfg_pkg::GAIN_CODE_MSB:
                              chan_cfg_pkg::GAIN_CODE_LSB];
    next_setting = '0;
    next_setting.gain_negative =
      chan2_analog_gain[chan_cfg_pkg::GAIN_POL_BIT];
    next_setting.analog_gain_half_db =
      gain_half_db(gcode, next_setting.gain_negative);
    next_setting.gain_code_reserved =
      (gcode > chan_cfg_pkg::GAIN_CODE_MAX);
    next_setting.volume_mute =
      (chan2_digital_volume == chan_cfg_pkg::VOL_CODE_MUTE);
    next_setting.volume_half_db =
      vol_half_db(chan2_digital_volume);
    next_setting.trim_tenth_db =
      trim_tenth_db(chan2_gain_trim_code);
    next_setting.phase_delay_cycles = chan2_phase_trim;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_setting <= '0;
    end else begin
      o_setting <= next_setting;
    end
  end

  assign phase_tap = chan2_phase_trim[PHASE_AW-1:0];

  // Only the low tap bits reach the delay line, so a line shallower than
  // the full code range wraps the programmed delay.
  chan_phase_delay #(
    .DEPTH (PHASE_DEPTH)
  ) u_delay (
    .i_clk      (i_clk),
    .i_rst      (i_rst),
    .i_mod_tick (i_mod_tick),
    .i_bit      (i_sample_bit),
    .i_delay    (phase_tap),
    .o_bit      (o_delayed_bit)
  );

endmodule

// ==== verilog/chan_cfg_pkg.sv ====
/*
  Package for the channel 2 configuration register bank: register offsets,
  reset values, field positions, code limits and the decoded setting carrier.
  Assumes a byte-wide register port with 8-bit addresses.
*/
package chan_cfg_pkg;

  localparam logic [7:0] ADDR_CHAN2_ANALOG_GAIN    = 8'h42;
  localparam logic [7:0] ADDR_CHAN2_DIGITAL_VOLUME = 8'h43;
  localparam logic [7:0] ADDR_CHAN2_GAIN_TRIM      = 8'h44;
  localparam logic [7:0] ADDR_CHAN2_PHASE_TRIM     = 8'h45;
  localparam logic [7:0] ADDR_CHAN3_DIGITAL_VOLUME = 8'h48;

  localparam logic [7:0] RST_ANALOG_GAIN    = 8'h00;
  localparam logic [7:0] RST_DIGITAL_VOLUME = 8'hC9;
  localparam logic [7:0] RST_GAIN_TRIM      = 8'h80;
  localparam logic [7:0] RST_PHASE_TRIM     = 8'h00;

  localparam int GAIN_CODE_MSB  = 7;
  localparam int GAIN_CODE_LSB  = 1;
  localparam int GAIN_POL_BIT   = 0;
  localparam int TRIM_CODE_MSB  = 7;
  localparam int TRIM_CODE_LSB  = 4;
  localparam logic [3:0] TRIM_RSVD_MASK = 4'h0;

  localparam logic [6:0] GAIN_CODE_MAX   = 7'h54;
  localparam logic [7:0] VOL_CODE_MUTE   = 8'h00;
  localparam logic [7:0] VOL_CODE_UNITY  = 8'hC9;
  localparam logic [3:0] TRIM_CODE_UNITY = 4'h8;

  // Decoded settings, all gains in signed half-dB or tenth-dB units.
  typedef struct packed {
    logic signed [8:0] analog_gain_half_db;
    logic              gain_negative;
    logic              gain_code_reserved;
    logic              volume_mute;
    logic signed [8:0] volume_half_db;
    logic signed [4:0] trim_tenth_db;
    logic [7:0]        phase_delay_cycles;
  } chan_setting_s;

endpackage

// ==== verilog/chan_phase_delay.sv ====
/*
  Phase trim delay line: delays the channel sample stream by a programmed
  number of modulator clock ticks, 0 to DEPTH-1.
  Assumes the modulator tick is a one-cycle enable synchronous to i_clk.
*/
`timescale 1ns/1ps
module chan_phase_delay #(
  parameter int DEPTH = 256
) (
  input  wire logic                     i_clk,
  input  wire logic                     i_rst,
  input  wire logic                     i_mod_tick,
  input  wire logic                     i_bit,
  input  wire logic [$clog2(DEPTH)-1:0] i_delay,
  output logic                          o_bit
);

  localparam int AW = $clog2(DEPTH);

  logic [DEPTH-1:0] history;
  logic [AW-1:0]    tap;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      history <= '0;
    end else if (i_mod_tick) begin
      history <= {history[DEPTH-2:0], i_bit};
    end
  end

  // Tap 0 is the current input, so code zero adds no delay.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tap <= '0;
    end else begin
      tap <= i_delay;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_bit <= 1'b0;
    end else if (tap == '0) begin
      o_bit <= i_bit;
    end else begin
      o_bit <= history[tap - AW'(1)];
    end
  end

endmodule

// ==== sim/chan2_cfg_checker.sv ====
/* Assertions on the channel 2 register bank ports.
   Assumes one clock domain and a bind onto every bank instance. */
`timescale 1ns/1ps
module chan2_cfg_checker #(
  parameter int PHASE_DEPTH = 256
) (
  input wire logic                        i_clk,
  input wire logic                        i_rst,
  input wire logic [7:0]                  i_addr,
  input wire logic [7:0]                  i_wdata,
  input wire logic                        i_wr,
  input wire logic                        i_rd,
  input wire logic [7:0]                  o_rdata,
  input wire logic                        o_rvalid,
  input wire chan_cfg_pkg::chan_setting_s o_setting
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  chan_cfg_pkg::chan_setting_s s;
  logic                        wv, wt;
  assign s = o_setting;
  assign wv = i_wr && i_addr == 8'h43;
  assign wt = i_wr && i_addr == 8'h44;
  AST_GAIN_MAX: assert property (
    !s.gain_code_reserved |-> s.analog_gain_half_db <= 9'sd84)
    else $error("gain over range");
  AST_GAIN_SIGN: assert property (
    i_wr && i_addr == 8'h42 |-> ##2
    {7'h00, s.gain_negative} == ($past(i_wdata, 2) & 8'h01))
    else $error("gain polarity wrong");
  AST_MUTE: assert property (
    wv |-> ##2 s.volume_mute == ($past(i_wdata, 2) == 8'h00))
    else $error("mute wrong");
  AST_VOL: assert property (
    wv |-> ##2 s.volume_half_db == 9'($past(i_wdata, 2)) - 9'd201)
    else $error("volume wrong");
  AST_TRIM: assert property (
    wt |-> ##2 s.trim_tenth_db == 5'($past(i_wdata, 2) >> 4) - 5'd8)
    else $error("trim wrong");
  AST_TRIM_RD: assert property (
    i_rd && i_addr == 8'h44 |=> o_rvalid && o_rdata[3:0] == 4'h0)
    else $error("trim low bits not zero");
  AST_PHASE: assert property (
    i_wr && i_addr == 8'h45 |-> ##2
    s.phase_delay_cycles == $past(i_wdata, 2))
    else $error("phase wrong");
  // Every reset value decodes to an all-zero setting.
  AST_RST: assert property (disable iff (1'b0)
    i_rst ##1 !i_rst |=> s == '0) else $error("reset setting wrong");
endmodule
bind chan2_cfg_bank chan2_cfg_checker #(.PHASE_DEPTH(PHASE_DEPTH)) u_chk (
  .i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_rvalid,
  .o_setting
);

// ==== sim/chan2_cfg_bank_tb.sv ====
/* Self-checking bench for the channel 2 register bank.
   Assumes one-cycle strobes and read data one cycle after the read. */
`timescale 1ns/1ps
module chan2_cfg_bank_tb;
  logic                        i_clk, i_rst, i_wr, i_rd;
  logic                        i_mod_tick, i_sample_bit;
  logic                        o_rvalid, o_delayed_bit;
  logic [7:0]                  i_addr, i_wdata, o_rdata;
  chan_cfg_pkg::chan_setting_s o_setting;
  int                          err_total, checked;
  chan2_cfg_bank dut (
    .i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .i_mod_tick,
    .i_sample_bit, .o_rdata, .o_rvalid, .o_setting, .o_delayed_bit
  );
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    // Settings follow one edge after the write is taken; two edges are waited here.
    repeat (2) @(posedge i_clk);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk(o_rvalid === 1'b1 ? {1'b0, o_rdata} : 9'h1FF, {1'b0, e});
  endtask
  task automatic t_regs;
    rd(8'h42, 8'h00);
    rd(8'h43, 8'hC9);
    rd(8'h44, 8'h80);
    rd(8'h45, 8'h00);
    rd(8'h48, 8'hC9);
    wr(8'h48, 8'h3C);
    rd(8'h48, 8'h3C);
    wr(8'h46, 8'h5A);
    rd(8'h46, 8'h00);
    // Gain code 84 is the top legal code; nothing above it is programmed.
    wr(8'h42, 8'hA8);
    chk(o_setting.analog_gain_half_db, 9'd84);
    chk(9'(o_setting.gain_negative), 9'h000);
    // Negative gain of 5 dB stays inside the 11 dB floor of that range.
    wr(8'h42, 8'h15);
    chk(o_setting.analog_gain_half_db, 9'h1F6);
    chk(9'(o_setting.gain_negative), 9'h001);
    rd(8'h42, 8'h15);
    // The reserved low trim bits are only ever written as zero.
    wr(8'h44, 8'hF0);
    chk({4'h0, o_setting.trim_tenth_db}, 9'h007);
    rd(8'h44, 8'hF0);
    wr(8'h44, 8'h00);
    chk({4'h0, o_setting.trim_tenth_db}, 9'h018);
    $display("register test done");
  endtask
  task automatic t_vol;
    logic [7:0] c [4] = '{8'h00, 8'h01, 8'hC9, 8'hFF};
    logic [8:0] v [4] = '{9'h137, 9'h138, 9'h000, 9'h036};
    foreach (c[i]) begin
      wr(8'h43, c[i]);
      chk({8'h00, o_setting.volume_mute}, 9'(c[i] == 8'h00));
      chk(o_setting.volume_half_db, v[i]);
    end
    $display("volume test done");
  endtask
  task automatic t_phase;
    logic [15:0] p = 16'hB4D2;
    int          n [3] = '{0, 3, 255};
    foreach (n[j]) begin
      wr(8'h45, 8'(n[j]));
      chk({1'b0, o_setting.phase_delay_cycles}, 9'(n[j]));
      for (int k = 0; k < n[j] + 16; k++) begin
        @(posedge i_clk);
        i_mod_tick <= 1'b1;
        i_sample_bit <= p[k % 16];
        @(posedge i_clk);
        i_mod_tick <= 1'b0;
        #1;
        if (k >= n[j])
          chk(9'(o_delayed_bit), 9'(p[(k - n[j]) % 16]));
      end
    end
    $display("phase test done");
  endtask
  task automatic t_rerun;
    @(posedge i_clk);
    i_rst <= 1'b1;
    @(posedge i_clk);
    i_rst <= 1'b0;
    rd(8'h42, 8'h00);
    rd(8'h43, 8'hC9);
    rd(8'h45, 8'h00);
    chk(o_setting.volume_half_db, 9'h000);
    chk(o_setting.analog_gain_half_db, 9'h000);
    $display("second reset test done");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    {i_rst, i_wr, i_rd, i_mod_tick, i_sample_bit} = 5'h10;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    t_regs();
    t_vol();
    t_phase();
    t_rerun();
    complete_run();
  end
  // The tests need about 710 cycles; this limit leaves wide margin.
  initial begin
    #100us;
    err_total++;
    complete_run();
  end
endmodule
